// [pkg/system_mode_control_params.svh]
`ifndef SYSTEM_MODE_CONTROL_PARAMS_SVH
`define SYSTEM_MODE_CONTROL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------------
`define SMC_ADDR_WIDTH 8
`define SMC_SYSTEM_CONTROL_OFFSET 8'h00
`define SMC_MODE_STATUS_OFFSET 8'h04

// ----------------------------------------------------------------------------
// Control register field positions.
// ----------------------------------------------------------------------------
`define SMC_FETCH_WIDTH_BIT 11
`define SMC_SATURATE_BIT 13
`define SMC_EXT_BUS_BIT 9
`define SMC_RAM_BIT 8
`define SMC_XFER_MODE_BIT 1

// ----------------------------------------------------------------------------
// Control register reset value and masks.
// ----------------------------------------------------------------------------
`define SMC_SYSTEM_CONTROL_RESET 16'hD103
`define SMC_SYSTEM_CONTROL_WRITABLE 16'h2B02
`define SMC_SYSTEM_CONTROL_FIXED_ONES 16'hD001
`define SMC_READ_ZERO_FILL 16'h0000

// ----------------------------------------------------------------------------
// Mode status register field positions.
// ----------------------------------------------------------------------------
`define SMC_STATUS_EXTENDED_BIT 0
`define SMC_STATUS_BUS16_BIT 1
`define SMC_STATUS_PINS_LSB 2
`define SMC_STATUS_VALID_BIT 5

// ----------------------------------------------------------------------------
// Mode pin codes.
// ----------------------------------------------------------------------------
`define SMC_PINS_MODE4 3'h4
`define SMC_PINS_MODE5 3'h5
`define SMC_PINS_RESET 3'h0

`endif

// [pkg/system_mode_control_pkg.sv]
// ----------------------------------------------------------------------------
// Types shared by the mode control block.
// ----------------------------------------------------------------------------
package system_mode_control_pkg;

  // Operating mode chosen by the mode pins.
  typedef enum logic [1:0] {
    mode_single_chip = 2'b00,
    mode_ext_wide = 2'b01,
    mode_ext_narrow = 2'b10
  } mode_type;

  // Width of the external data bus.
  typedef enum logic [1:0] {
    bus_off = 2'b00,
    bus_narrow = 2'b01,
    bus_wide = 2'b10
  } bus_state_type;

endpackage : system_mode_control_pkg

// [pkg/mode_cfg_if.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Startup mode handed from the mode decoder to the control logic.
// ----------------------------------------------------------------------------
interface mode_cfg_if;
  import system_mode_control_pkg::*;

  mode_type mode;
  logic extended;
  logic start_wide;
  logic valid;
  logic [2:0] pins;

  modport decoder (output mode, output extended, output start_wide, output valid, output pins);
  modport control (input mode, input extended, input start_wide, input valid, input pins);

endinterface : mode_cfg_if

`default_nettype wire

// [core/mode_decoder.sv]
`timescale 1ns/1ps
`default_nettype none

`include "system_mode_control_params.svh"

module mode_decoder
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic mode_pin_2,
  input wire logic mode_pin_1,
  input wire logic mode_pin_0,
  mode_cfg_if.decoder cfg
);
  import system_mode_control_pkg::*;

  logic [2:0] next_pins;
  logic next_valid;
  mode_type next_mode;

  // ----------------------------------------------------------------------------
  // Strap capture.
  // ----------------------------------------------------------------------------

  // The pins are caught once, on the first edge after reset release.
  always_comb
  begin
    next_pins = cfg.pins;
    next_valid = 1'b1;
    next_mode = cfg.mode;
    if (!cfg.valid)
    begin
      next_pins = {mode_pin_2, mode_pin_1, mode_pin_0};
      unique case ({mode_pin_2, mode_pin_1, mode_pin_0})
        `SMC_PINS_MODE4: next_mode = mode_ext_wide;
        `SMC_PINS_MODE5: next_mode = mode_ext_narrow;
        default: next_mode = mode_single_chip;
      endcase
    end
  end

  // Registers the captured mode; reset gives constants only.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg.pins <= `SMC_PINS_RESET;
      cfg.valid <= 1'b0;
      cfg.mode <= mode_single_chip;
    end
    else
    begin
      cfg.pins <= next_pins;
      cfg.valid <= next_valid;
      cfg.mode <= next_mode;
    end
  end

  // Modes 4 and 5 are the external extended modes.
  assign cfg.extended = (cfg.mode != mode_single_chip);
  assign cfg.start_wide = (cfg.mode == mode_ext_wide);

endmodule : mode_decoder

`default_nettype wire

// [core/system_mode_control.sv]
// The plain strobed port and the register addresses were chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

`include "system_mode_control_params.svh"

module system_mode_control
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic mode_pin_2,
  input wire logic mode_pin_1,
  input wire logic mode_pin_0,
  input wire logic [7:0] address,
  input wire logic [15:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [15:0] read_data,
  input wire logic all_areas_8bit,
  input wire logic all_areas_16bit,
  input wire logic write_buffer_enable,
  output logic external_bus_enable,
  output logic onchip_ram_enable,
  output logic transfer_ctrl_address_mode,
  output logic saturate_enable,
  output logic fetch_width_16,
  output logic advanced_mode,
  output logic onchip_rom_enable,
  output logic bus_width_16,
  output logic address_port_enable,
  output logic data_port_h_enable,
  output logic data_port_i_enable,
  output logic bus_control_enable,
  output logic concurrent_cycle_enable
);
  import system_mode_control_pkg::*;

  // ----------------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------------
  mode_cfg_if cfg ();

  logic [15:0] system_control;
  logic [15:0] next_system_control;
  logic [15:0] control_view;
  logic [15:0] status_view;
  logic [15:0] next_read_data;
  logic select_control;
  logic select_status;

  bus_state_type bus_state;
  bus_state_type next_bus_state;

  logic next_external_bus_enable;
  logic next_advanced_mode;
  logic next_onchip_rom_enable;
  logic next_bus_width_16;
  logic next_address_port_enable;
  logic next_data_port_h_enable;
  logic next_data_port_i_enable;
  logic next_bus_control_enable;
  logic next_concurrent_cycle_enable;

  // ----------------------------------------------------------------------------
  // Startup mode.
  // ----------------------------------------------------------------------------

  // Catches the mode pins after reset and decodes the operating mode.
  mode_decoder decoder_inst
  (
    .clock(clock),
    .arst_n(arst_n),
    .mode_pin_2(mode_pin_2),
    .mode_pin_1(mode_pin_1),
    .mode_pin_0(mode_pin_0),
    .cfg(cfg.decoder)
  );

  // ----------------------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------------------

  // Full address compare; any other address reads zero and ignores writes.
  assign select_control = (address == `SMC_SYSTEM_CONTROL_OFFSET);
  assign select_status = (address == `SMC_MODE_STATUS_OFFSET);

  // ----------------------------------------------------------------------------
  // Control register.
  // ----------------------------------------------------------------------------

  // Stores the writable bits together with the fixed ones, which a write merges in and the reset value already holds.
  always_comb
  begin
    next_system_control = system_control;
    if (write_strobe && select_control)
    begin
      next_system_control = (write_data & `SMC_SYSTEM_CONTROL_WRITABLE) | `SMC_SYSTEM_CONTROL_FIXED_ONES;
    end
    if (cfg.extended)
    begin
      next_system_control[`SMC_EXT_BUS_BIT] = 1'b1;
    end
  end

  // Reset value keeps bus enable 0, RAM enable 1, transfer mode short.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      system_control <= `SMC_SYSTEM_CONTROL_RESET;
    end
    else
    begin
      system_control <= next_system_control;
    end
  end

  // ----------------------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------------------

  // The bus enable reads 1 in extended modes even before the store catches up.
  always_comb
  begin
    control_view = (system_control & `SMC_SYSTEM_CONTROL_WRITABLE) | `SMC_SYSTEM_CONTROL_FIXED_ONES;
    if (cfg.extended)
    begin
      control_view[`SMC_EXT_BUS_BIT] = 1'b1;
    end
  end

  // Status shows the captured mode pins and the live bus width.
  always_comb
  begin
    status_view = `SMC_READ_ZERO_FILL;
    status_view[`SMC_STATUS_EXTENDED_BIT] = cfg.extended;
    status_view[`SMC_STATUS_BUS16_BIT] = (bus_state == bus_wide);
    status_view[`SMC_STATUS_PINS_LSB +: 3] = cfg.pins;
    status_view[`SMC_STATUS_VALID_BIT] = cfg.valid;
  end

  // Read data stand for exactly the cycle after the read strobe.
  always_comb
  begin
    next_read_data = `SMC_READ_ZERO_FILL;
    if (read_strobe && select_control)
    begin
      next_read_data = control_view;
    end
    else if (read_strobe && select_status)
    begin
      next_read_data = status_view;
    end
  end

  // Registers the read answer.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      read_data <= `SMC_READ_ZERO_FILL;
    end
    else
    begin
      read_data <= next_read_data;
    end
  end

  // ----------------------------------------------------------------------------
  // Bus width state machine.
  // ----------------------------------------------------------------------------

  // Starts at the mode's initial width and follows the area settings.
  always_comb
  begin
    next_bus_state = bus_state;
    unique case (bus_state)
      bus_off:
      begin
        if (cfg.valid && cfg.extended)
        begin
          next_bus_state = cfg.start_wide ? bus_wide : bus_narrow;
        end
      end
      bus_narrow:
      begin
        if (cfg.mode == mode_ext_wide && !all_areas_8bit)
        begin
          next_bus_state = bus_wide;
        end
        else if (cfg.mode == mode_ext_narrow && all_areas_16bit)
        begin
          next_bus_state = bus_wide;
        end
      end
      bus_wide:
      begin
        if (cfg.mode == mode_ext_wide && all_areas_8bit)
        begin
          next_bus_state = bus_narrow;
        end
        else if (cfg.mode == mode_ext_narrow && !all_areas_16bit)
        begin
          next_bus_state = bus_narrow;
        end
      end
      default:
      begin
        next_bus_state = bus_off;
      end
    endcase
  end

  // Holds the current bus width.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_state <= bus_off;
    end
    else
    begin
      bus_state <= next_bus_state;
    end
  end

  // ----------------------------------------------------------------------------
  // Pin roles and mode outputs.
  // ----------------------------------------------------------------------------

  // Ports take bus roles only while the external bus is enabled.
  always_comb
  begin
    next_external_bus_enable = control_view[`SMC_EXT_BUS_BIT];
    next_advanced_mode = cfg.extended;
    next_onchip_rom_enable = !cfg.extended;
    next_bus_width_16 = (bus_state == bus_wide);
    next_address_port_enable = 1'b0;
    next_data_port_h_enable = 1'b0;
    next_data_port_i_enable = 1'b0;
    next_bus_control_enable = 1'b0;
    if (next_external_bus_enable && bus_state != bus_off)
    begin
      next_address_port_enable = 1'b1;
      next_data_port_h_enable = 1'b1;
      next_data_port_i_enable = (bus_state == bus_wide);
      next_bus_control_enable = 1'b1;
    end
    // A buffered write lets the internal bus run on during the external cycle.
    next_concurrent_cycle_enable = next_external_bus_enable && write_buffer_enable;
  end

  // Registers every derived output so that each port leaves a flip-flop.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      external_bus_enable <= 1'b0;
      advanced_mode <= 1'b0;
      onchip_rom_enable <= 1'b0;
      bus_width_16 <= 1'b0;
      address_port_enable <= 1'b0;
      data_port_h_enable <= 1'b0;
      data_port_i_enable <= 1'b0;
      bus_control_enable <= 1'b0;
      concurrent_cycle_enable <= 1'b0;
    end
    else
    begin
      external_bus_enable <= next_external_bus_enable;
      advanced_mode <= next_advanced_mode;
      onchip_rom_enable <= next_onchip_rom_enable;
      bus_width_16 <= next_bus_width_16;
      address_port_enable <= next_address_port_enable;
      data_port_h_enable <= next_data_port_h_enable;
      data_port_i_enable <= next_data_port_i_enable;
      bus_control_enable <= next_bus_control_enable;
      concurrent_cycle_enable <= next_concurrent_cycle_enable;
    end
  end

  // ----------------------------------------------------------------------------
  // Direct control bits.
  // ----------------------------------------------------------------------------

  // These follow the control register straight from its flip-flops.
  assign onchip_ram_enable = system_control[`SMC_RAM_BIT];
  assign transfer_ctrl_address_mode = system_control[`SMC_XFER_MODE_BIT];
  assign saturate_enable = system_control[`SMC_SATURATE_BIT];
  assign fetch_width_16 = system_control[`SMC_FETCH_WIDTH_BIT];

endmodule : system_mode_control

`default_nettype wire

// [tb/system_mode_control_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

`include "system_mode_control_params.svh"

// ----------
// Port checks for the mode control block.
// ----------
module system_mode_control_assertions
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] address,
  input wire logic [15:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [15:0] read_data,
  input wire logic all_areas_8bit,
  input wire logic all_areas_16bit,
  input wire logic write_buffer_enable,
  input wire logic external_bus_enable,
  input wire logic onchip_ram_enable,
  input wire logic transfer_ctrl_address_mode,
  input wire logic advanced_mode,
  input wire logic onchip_rom_enable,
  input wire logic bus_width_16,
  input wire logic address_port_enable,
  input wire logic data_port_h_enable,
  input wire logic data_port_i_enable,
  input wire logic bus_control_enable,
  input wire logic concurrent_cycle_enable
);
  // Every check runs on the system clock and sleeps during reset.
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  ext_fixed_a: assert property (advanced_mode |-> external_bus_enable)
    else $error("bus enable low in extended mode");
  rom_off_a: assert property (advanced_mode |-> !onchip_rom_enable)
    else $error("rom enabled in extended mode");
  wide_ports_a: assert property (bus_width_16 |->
    data_port_i_enable && data_port_h_enable && address_port_enable && bus_control_enable)
    else $error("wide bus without all port roles");
  narrow_bus_a: assert property ((advanced_mode && all_areas_8bit && !all_areas_16bit) [*4] |->
    !bus_width_16 && !data_port_i_enable && data_port_h_enable)
    else $error("bus not narrow");
  wide_bus_a: assert property ((advanced_mode && all_areas_16bit && !all_areas_8bit) [*4] |->
    bus_width_16)
    else $error("bus not wide");
  overlap_off_a: assert property ((!write_buffer_enable) [*2] |-> !concurrent_cycle_enable)
    else $error("overlap without write buffer");
  reserved_read_a: assert property ($past(read_strobe) &&
    $past(address) == `SMC_SYSTEM_CONTROL_OFFSET |->
    read_data[10] == 1'b0 && read_data[7:2] == 6'h00 && read_data[0] == 1'b1)
    else $error("reserved bits read wrong");
  ext_read_a: assert property ($past(read_strobe) &&
    $past(address) == `SMC_SYSTEM_CONTROL_OFFSET && advanced_mode |-> read_data[9] == 1'b1)
    else $error("bus enable reads low in extended mode");
  ctrl_bits_a: assert property (write_strobe && address == `SMC_SYSTEM_CONTROL_OFFSET |=>
    {onchip_ram_enable, transfer_ctrl_address_mode} == $past({write_data[8], write_data[1]}))
    else $error("ram or transfer mode not written");
  // A write in the cycles just after reset release may still meet a mode that is turning extended.
  ext_write_a: assert property (write_strobe && address == `SMC_SYSTEM_CONTROL_OFFSET && !advanced_mode
    ##2 !advanced_mode |-> external_bus_enable == $past(write_data[9], 2))
    else $error("bus enable not written");
endmodule : system_mode_control_assertions

`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------
// Register and mode tests.
// ----------
module tb;
  logic clock, arst_n, mode_pin_2, mode_pin_1, mode_pin_0, write_strobe, read_strobe;
  logic all_areas_8bit, all_areas_16bit, write_buffer_enable;
  logic [7:0] address;
  logic [15:0] write_data, read_data;
  logic external_bus_enable, onchip_ram_enable, transfer_ctrl_address_mode, saturate_enable, fetch_width_16;
  logic advanced_mode, onchip_rom_enable, bus_width_16, address_port_enable, data_port_h_enable;
  logic data_port_i_enable, bus_control_enable, concurrent_cycle_enable;
  int err_count, compares, cycles;
  wire logic [15:0] roles = {8'h00, external_bus_enable, advanced_mode, onchip_rom_enable, bus_width_16,
    address_port_enable, data_port_h_enable, data_port_i_enable, bus_control_enable};
  wire logic [15:0] ctl = {11'h000, saturate_enable, fetch_width_16, onchip_ram_enable,
    transfer_ctrl_address_mode, concurrent_cycle_enable};

  system_mode_control dut (.clock(clock), .arst_n(arst_n), .mode_pin_2(mode_pin_2), .mode_pin_1(mode_pin_1),
    .mode_pin_0(mode_pin_0), .address(address), .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data), .all_areas_8bit(all_areas_8bit),
    .all_areas_16bit(all_areas_16bit), .write_buffer_enable(write_buffer_enable),
    .external_bus_enable(external_bus_enable), .onchip_ram_enable(onchip_ram_enable),
    .transfer_ctrl_address_mode(transfer_ctrl_address_mode), .saturate_enable(saturate_enable),
    .fetch_width_16(fetch_width_16), .advanced_mode(advanced_mode), .onchip_rom_enable(onchip_rom_enable),
    .bus_width_16(bus_width_16), .address_port_enable(address_port_enable),
    .data_port_h_enable(data_port_h_enable), .data_port_i_enable(data_port_i_enable),
    .bus_control_enable(bus_control_enable), .concurrent_cycle_enable(concurrent_cycle_enable));

  // The clock toggles every half period of 25 ns.
  always #25 clock = ~clock;

  // Cuts a hung run short.
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_count++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    write_strobe <= 1'b1;
    address <= a;
    write_data <= d;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    read_strobe <= 1'b1;
    address <= a;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1;
    check(read_data, exp);
  endtask : rd

  task automatic restart(input logic [2:0] pins);
    @(posedge clock);
    arst_n <= 1'b0;
    {mode_pin_2, mode_pin_1, mode_pin_0} <= pins;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    settle(4);
  endtask : restart

  task automatic complete_run();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  // Single-chip mode first, then both extended modes.
  initial
  begin
    {clock, arst_n, mode_pin_2, mode_pin_1, mode_pin_0, write_strobe, read_strobe} = 7'h00;
    {all_areas_8bit, all_areas_16bit, write_buffer_enable, address, write_data} = 27'h0;
    {err_count, compares, cycles} = {32'h0, 32'h0, 32'h0};
    restart(3'h0);
    rd(8'h00, 16'hD103);
    check(roles, 16'h0020);
    check(ctl, 16'h0006);
    wr(8'h00, 16'hFFFF);
    rd(8'h00, 16'hFB03);
    check(roles, 16'h00A0);
    @(posedge clock);
    write_buffer_enable <= 1'b1;
    settle(2);
    check(ctl, 16'h001F);
    // No external cycle and no on-chip RAM access is running while both enables are cleared.
    wr(8'h00, 16'h0001);
    settle(2);
    check(ctl, 16'h0000);
    check(roles, 16'h0020);
    rd(8'h04, 16'h0020);
    wr(8'h10, 16'hFFFF);
    rd(8'h10, 16'h0000);
    rd(8'h00, 16'hD001);
    for (int m = 0; m < 2; m++)
    begin
      restart(m[0] ? 3'h5 : 3'h4);
      rd(8'h00, 16'hD303);
      rd(8'h04, m[0] ? 16'h0035 : 16'h0033);
      wr(8'h00, 16'hD101);
      rd(8'h00, 16'hD301);
      check(roles, m[0] ? 16'h00CD : 16'h00DF);
      @(posedge clock);
      all_areas_16bit <= m[0];
      all_areas_8bit <= !m[0];
      settle(3);
      check(roles, m[0] ? 16'h00DF : 16'h00CD);
      @(posedge clock);
      all_areas_16bit <= 1'b0;
      all_areas_8bit <= 1'b0;
      settle(3);
      check(roles, m[0] ? 16'h00CD : 16'h00DF);
    end
    complete_run();
  end
endmodule : tb

bind system_mode_control system_mode_control_assertions chk (.clock(clock), .arst_n(arst_n),
  .address(address), .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
  .read_data(read_data), .all_areas_8bit(all_areas_8bit), .all_areas_16bit(all_areas_16bit),
  .write_buffer_enable(write_buffer_enable), .external_bus_enable(external_bus_enable),
  .onchip_ram_enable(onchip_ram_enable), .transfer_ctrl_address_mode(transfer_ctrl_address_mode),
  .advanced_mode(advanced_mode), .onchip_rom_enable(onchip_rom_enable), .bus_width_16(bus_width_16),
  .address_port_enable(address_port_enable), .data_port_h_enable(data_port_h_enable),
  .data_port_i_enable(data_port_i_enable), .bus_control_enable(bus_control_enable),
  .concurrent_cycle_enable(concurrent_cycle_enable));

`default_nettype wire
